//--- verilog/iepu_pkg.sv
// Constants and types of the interrupt enable and priority unit.
// Assumes an 8-bit special-register bus and a CPU sequencer that
// reports instruction ends and return-from-interrupt completion.
//
// Operation
// RULE1: Sample and priority-decode pending requests every clock
// RULE2: Response is one detect plus four call cycles
// RULE3: After return, one instruction runs before next call
// RULE4: Worst response eighteen clocks through return and divide
// RULE5: Equal or higher running level blocks new requests
// RULE6: Global enable top bit gates every source mask
// RULE7: Enable bit six is plain software flag
// RULE8: Enable bits five to zero mask base sources
// RULE9: Priority bits five to zero pick high level
// RULE10: Priority top bits read ones, writes ignored
// RULE11: First extended enable masks eight peripheral sources
// RULE12: Second extended enable masks remaining sources
// RULE13: Second extended enable bit six reads zero
// RULE14: High level preempts low, high never preempted
// RULE15: Same level resolved by lowest source order
// RULE16: Flags pend regardless of mask; masked ignored
// RULE17: Enable and priority also take bit writes
package iepu_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] IEPU_ADDR_PEN    = 8'ha8;  // primary_interrupt_enable
  localparam logic [7:0] IEPU_ADDR_PRI    = 8'hb8;  // primary_interrupt_priority
  localparam logic [7:0] IEPU_ADDR_XEN1   = 8'he6;  // extended_interrupt_enable_one
  localparam logic [7:0] IEPU_ADDR_XEN2   = 8'he7;  // extended_interrupt_enable_two
  localparam logic [7:0] IEPU_ADDR_STAT   = 8'hd9;  // Sticky event status
  localparam logic [7:0] IEPU_ADDR_MASK   = 8'hda;  // Event interrupt mask
  localparam logic [7:0] IEPU_RESET_VAL   = 8'h00;  // Reset of all registers
  localparam logic [7:0] IEPU_RD_UNMAPPED = 8'h00;  // Answer to unknown address

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int          IEPU_BIT_GLOBAL   = 7;      // global_irq_enable
  localparam int          IEPU_BIT_SOFTFLAG = 6;      // soft_flag_zero
  localparam int          IEPU_BASE_SRC     = 6;      // Sources in primary regs
  localparam logic [1:0]  IEPU_PRI_TOP_READ = 2'h3;   // Fixed top of priority
  localparam int          IEPU_XEN2_RSVD    = 6;      // Reserved enable bit
  localparam logic [4:0]  IEPU_BITADR_PEN   = 5'h15;  // Bit space 0xa8..0xaf
  localparam logic [4:0]  IEPU_BITADR_PRI   = 5'h17;  // Bit space 0xb8..0xbf

  // ************************************************************
  // Sources and vectors
  // ************************************************************
  localparam int          IEPU_NUM_SRC   = 22;        // Orders 0 to 21
  localparam int          IEPU_IDX_W     = 5;         // Width of a source order
  localparam logic [15:0] IEPU_VEC_BASE  = 16'h0003;  // Vector of order 0
  localparam int          IEPU_VEC_SHIFT = 3;         // Eight bytes per vector

  // ************************************************************
  // Event status bits
  // ************************************************************
  localparam int IEPU_EV_ENTER   = 0;  // A service call completed
  localparam int IEPU_EV_PREEMPT = 1;  // High level entered over low
  localparam int IEPU_EV_RETURN  = 2;  // A return popped a level
  localparam int IEPU_NUM_EV     = 3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int IEPU_CLK_NS     = 40;                         // 25 MHz clock
  localparam int IEPU_DETECT_CYC = 1;                          // Detect stage
  localparam int IEPU_LCALL_CYC  = 4;                          // Call length
  localparam int IEPU_MIN_RESP   = IEPU_DETECT_CYC + IEPU_LCALL_CYC;
  localparam int IEPU_CNT_W      = 2;                          // Call counter

  // Call sequencer states
  typedef enum logic [0:0] {
    IEPU_IDLE = 1'b0,
    IEPU_CALL = 1'b1
  } iepu_state_t;

endpackage

//--- verilog/iepu_top.sv
// Interrupt enable and priority unit: mask and level registers,
// per-clock request decode, and the call sequencer that hands the
// winning vector to the CPU. Assumes the CPU pulses instruction ends
// and holds off fetching while the call is in progress.
`timescale 1ns/10ps
module iepu_top
  import iepu_pkg::*;
#(
  parameter int NUM_SRC = IEPU_NUM_SRC
)(
  // Clock and reset
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_NRST,
  // Register port
  input  wire logic [7:0]            I_ADDR,
  input  wire logic [7:0]            I_WDATA,
  input  wire logic                  I_WR,
  input  wire logic                  I_RD,
  output logic      [7:0]            O_RDATA,
  // Single-bit access
  input  wire logic [7:0]            I_BIT_ADDR,
  input  wire logic                  I_BIT_VAL,
  input  wire logic                  I_BIT_WR,
  // Pending flags, index is source order
  input  wire logic [NUM_SRC-1:0]    I_PENDING,
  // CPU sequencer
  input  wire logic                  I_INSTR_DONE,
  input  wire logic                  I_RETI_DONE,
  output logic                       O_CALL_BUSY,
  output logic                       O_CALL_ENTER,
  output logic      [15:0]           O_VECTOR,
  output logic      [NUM_SRC-1:0]    O_ACK,
  // Event interrupt
  output logic                       O_IRQ
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0]            pen_q;        // primary_interrupt_enable
  logic [5:0]            pri_q;        // primary_interrupt_priority low bits
  logic [7:0]            xen1_q;       // extended_interrupt_enable_one
  logic [7:0]            xen2_q;       // extended_interrupt_enable_two
  logic [IEPU_NUM_EV-1:0] stat_q;      // Sticky events
  logic [IEPU_NUM_EV-1:0] emask_q;     // Event mask
  logic [IEPU_NUM_EV-1:0] ev_set;      // Events this cycle
  logic [NUM_SRC-1:0]    enable_vec;   // Per-source enable
  logic [NUM_SRC-1:0]    level_vec;    // Per-source high level
  logic [NUM_SRC-1:0]    eligible;     // Pending and enabled
  logic [NUM_SRC-1:0]    req_hi;       // Eligible at high level
  logic [NUM_SRC-1:0]    req_lo;       // Eligible at low level
  logic                  act_hi_q;     // High level routine running
  logic                  act_lo_q;     // Low level routine running
  logic                  win_valid;    // Combinational winner
  logic [IEPU_IDX_W-1:0] win_idx;
  logic                  win_hi;
  logic                  start_call;   // Begin the call sequence
  iepu_state_t           state_q;
  logic [IEPU_CNT_W-1:0] cnt_q;        // Call cycle counter
  logic [IEPU_IDX_W-1:0] call_idx_q;   // Source being called
  logic                  call_hi_q;    // Level being called
  logic                  call_last;    // Final call cycle
  logic                  bit_pen;      // Bit write hits enable
  logic                  bit_pri;      // Bit write hits priority
  logic [2:0]            bit_pos;      // Bit inside the byte

  // Lowest set order of a request vector
  function automatic logic [IEPU_IDX_W-1:0] lowest(input logic [NUM_SRC-1:0] v);
    logic [IEPU_IDX_W-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = IEPU_IDX_W'(i);
      end
    end
    return r;
  endfunction

  // ************************************************************
  // Register writes
  // ************************************************************
  assign bit_pos = I_BIT_ADDR[2:0];
  assign bit_pen = I_BIT_WR && (I_BIT_ADDR[7:3] == IEPU_BITADR_PEN);
  assign bit_pri = I_BIT_WR && (I_BIT_ADDR[7:3] == IEPU_BITADR_PRI);

  // Primary enable, byte or bit access; bit 6 is only stored
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pen_q <= IEPU_RESET_VAL;
    end
    else if (I_WR && (I_ADDR == IEPU_ADDR_PEN))
    begin
      pen_q <= I_WDATA;  // see RULE7
    end
    else if (bit_pen)
    begin
      pen_q[bit_pos] <= I_BIT_VAL;  // see RULE17
    end
  end

  // Primary priority; the top two bits hold no state at all
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pri_q <= IEPU_RESET_VAL[5:0];
    end
    else if (I_WR && (I_ADDR == IEPU_ADDR_PRI))
    begin
      pri_q <= I_WDATA[5:0];  // see RULE10
    end
    else if (bit_pri && (bit_pos < 3'(IEPU_BASE_SRC)))
    begin
      pri_q[bit_pos] <= I_BIT_VAL;  // see RULE17
    end
  end

  // Extended enables; reserved bit is never stored
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      xen1_q <= IEPU_RESET_VAL;
      xen2_q <= IEPU_RESET_VAL;
    end
    else if (I_WR)
    begin
      if (I_ADDR == IEPU_ADDR_XEN1)
      begin
        xen1_q <= I_WDATA;  // see RULE11
      end
      if (I_ADDR == IEPU_ADDR_XEN2)
      begin
        xen2_q <= I_WDATA;
        xen2_q[IEPU_XEN2_RSVD] <= 1'b0;  // see RULE13
      end
    end
  end

  // ************************************************************
  // Event status and interrupt
  // ************************************************************
  // Set wins over a write-one clear so no event is lost
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      stat_q <= '0;
    end
    else if (I_WR && (I_ADDR == IEPU_ADDR_STAT))
    begin
      stat_q <= (stat_q & ~I_WDATA[IEPU_NUM_EV-1:0]) | ev_set;
    end
    else
    begin
      stat_q <= stat_q | ev_set;
    end
  end

  // Event mask
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      emask_q <= '0;
    end
    else if (I_WR && (I_ADDR == IEPU_ADDR_MASK))
    begin
      emask_q <= I_WDATA[IEPU_NUM_EV-1:0];
    end
  end

  assign ev_set[IEPU_EV_ENTER]   = call_last;
  assign ev_set[IEPU_EV_PREEMPT] = call_last && call_hi_q && act_lo_q;
  assign ev_set[IEPU_EV_RETURN]  = I_RETI_DONE && (act_hi_q || act_lo_q);
  assign O_IRQ = |(stat_q & emask_q);

  // ************************************************************
  // Register reads
  // ************************************************************
  // Data stand in the cycle after the read strobe only
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_RDATA <= IEPU_RD_UNMAPPED;
    end
    else if (I_RD)
    begin
      unique case (I_ADDR)
        IEPU_ADDR_PEN:  O_RDATA <= pen_q;
        IEPU_ADDR_PRI:  O_RDATA <= {IEPU_PRI_TOP_READ, pri_q};  // see RULE10
        IEPU_ADDR_XEN1: O_RDATA <= xen1_q;
        IEPU_ADDR_XEN2: O_RDATA <= xen2_q;                      // see RULE13
        IEPU_ADDR_STAT: O_RDATA <= 8'(stat_q);
        IEPU_ADDR_MASK: O_RDATA <= 8'(emask_q);
        default:        O_RDATA <= IEPU_RD_UNMAPPED;
      endcase
    end
    else
    begin
      O_RDATA <= IEPU_RD_UNMAPPED;
    end
  end

  // ************************************************************
  // Request decode
  // ************************************************************
  // Order 0..5 primary, 6..13 first extended, 14..21 second extended;
  // the reserved order 20 follows the always-zero enable bit
  assign enable_vec = {xen2_q, xen1_q, pen_q[IEPU_BASE_SRC-1:0]};  // see RULE8, see RULE12
  // Extended levels live elsewhere, so those sources stay low here
  assign level_vec  = {(NUM_SRC - IEPU_BASE_SRC)'(0), pri_q};      // see RULE9
  // Flags arrive unmasked; masking only hides them from arbitration
  assign eligible   = I_PENDING & enable_vec & {NUM_SRC{pen_q[IEPU_BIT_GLOBAL]}};  // see RULE6
  assign req_hi     = eligible & level_vec;   // see RULE16
  assign req_lo     = eligible & ~level_vec;

  // High wins; a running high routine blocks all, low blocks low
  always_comb
  begin
    win_valid = 1'b0;
    win_idx   = '0;
    win_hi    = 1'b0;
    if (|req_hi && !act_hi_q)
    begin
      win_valid = 1'b1;                       // see RULE14
      win_idx   = lowest(req_hi);             // see RULE15
      win_hi    = 1'b1;
    end
    else if (|req_lo && !act_hi_q && !act_lo_q)
    begin
      win_valid = 1'b1;                       // see RULE5
      win_idx   = lowest(req_lo);
    end
  end

  // ************************************************************
  // Call sequencer
  // ************************************************************
  // This cycle's decode is the detect cycle: a winner seen at an
  // instruction end starts the four call cycles at the next edge
  // A return end never starts a call, so one whole instruction,
  // a divide at worst, runs before the next routine is entered
  assign start_call = (state_q == IEPU_IDLE) && win_valid  // see RULE1
                      && I_INSTR_DONE                      // see RULE2
                      && !I_RETI_DONE;                     // see RULE3, see RULE4
  assign call_last = (state_q == IEPU_CALL)
                     && (cnt_q == IEPU_CNT_W'(IEPU_LCALL_CYC - 1));

  // Call state and counter
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state_q    <= IEPU_IDLE;
      cnt_q      <= '0;
      call_idx_q <= '0;
      call_hi_q  <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        IEPU_IDLE:
        begin
          if (start_call)
          begin
            state_q    <= IEPU_CALL;
            cnt_q      <= '0;
            call_idx_q <= win_idx;
            call_hi_q  <= win_hi;
          end
        end
        IEPU_CALL:
        begin
          if (call_last)
          begin
            state_q <= IEPU_IDLE;
          end
          cnt_q <= cnt_q + 1'b1;
        end
      endcase
    end
  end

  // Running levels: pushed at call end, return pops the highest
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      act_hi_q <= 1'b0;
      act_lo_q <= 1'b0;
    end
    else if (call_last)
    begin
      if (call_hi_q)
      begin
        act_hi_q <= 1'b1;
      end
      else
      begin
        act_lo_q <= 1'b1;
      end
    end
    else if (I_RETI_DONE)
    begin
      if (act_hi_q)
      begin
        act_hi_q <= 1'b0;
      end
      else
      begin
        act_lo_q <= 1'b0;
      end
    end
  end

  // Entry outputs come from flip-flops
  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_CALL_ENTER <= 1'b0;
      O_VECTOR     <= '0;
      O_ACK        <= '0;
    end
    else
    begin
      O_CALL_ENTER <= call_last;
      O_ACK        <= '0;
      if (call_last)
      begin
        O_VECTOR <= IEPU_VEC_BASE + (16'(call_idx_q) << IEPU_VEC_SHIFT);
        O_ACK    <= NUM_SRC'(1) << call_idx_q;
      end
    end
  end

  assign O_CALL_BUSY = (state_q == IEPU_CALL);

endmodule

//--- testbench/iepu_top_assertions.sv
// Port-level checks of the interrupt enable and priority unit.
// Assumes one clock domain and binding onto every iepu_top instance.
`timescale 1ns/10ps
module iepu_top_assertions
  import iepu_pkg::*;
#(
  parameter int NUM_SRC = IEPU_NUM_SRC
)(
  // Clock and reset
  input wire logic               I_CLOCK,
  input wire logic               I_NRST,
  // Register and CPU side
  input wire logic [7:0]         I_ADDR,
  input wire logic               I_RD,
  input wire logic [7:0]         O_RDATA,
  input wire logic               I_INSTR_DONE,
  input wire logic               I_RETI_DONE,
  input wire logic               O_CALL_BUSY,
  input wire logic               O_CALL_ENTER,
  input wire logic [15:0]        O_VECTOR,
  input wire logic [NUM_SRC-1:0] O_ACK
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);

  // ****************************************************
  // Call sequence
  // ****************************************************
  // Four busy cycles then the entry pulse
  sequence s_call;
    O_CALL_BUSY [*4] ##1 (!O_CALL_BUSY && O_CALL_ENTER);
  endsequence

  a_busy_four: assert property ($rose(O_CALL_BUSY) |-> s_call)
    else $error("call busy length wrong");
  a_enter_after: assert property (O_CALL_ENTER |-> $past(O_CALL_BUSY) && !O_CALL_BUSY)
    else $error("entry without call");
  a_start_cause: assert property ($rose(O_CALL_BUSY) |-> $past(I_INSTR_DONE) && !$past(I_RETI_DONE))
    else $error("call not at instruction end");
  // Vector must name the one acknowledged source
  a_ack_match: assert property (O_CALL_ENTER |-> $onehot(O_ACK) && O_VECTOR[15:8] == 8'h00 &&
                                O_VECTOR[2:0] == 3'h3 && O_ACK[O_VECTOR[7:3]])
    else $error("vector and ack disagree");
  a_ack_quiet: assert property (!O_CALL_ENTER |-> O_ACK == '0)
    else $error("ack outside entry");
  a_vec_hold: assert property (!O_CALL_ENTER |-> $stable(O_VECTOR))
    else $error("vector moved");

  // ****************************************************
  // Register reads
  // ****************************************************
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read");
  a_pri_top: assert property ($past(I_RD && I_ADDR == 8'hb8) |-> O_RDATA[7:6] == 2'h3)
    else $error("priority top bits");
  a_xen2_rsvd: assert property ($past(I_RD && I_ADDR == 8'he7) |-> !O_RDATA[6])
    else $error("reserved enable bit");
endmodule

bind iepu_top iepu_top_assertions #(.NUM_SRC(NUM_SRC)) u_chk (
  .I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_INSTR_DONE(I_INSTR_DONE), .I_RETI_DONE(I_RETI_DONE), .O_CALL_BUSY(O_CALL_BUSY),
  .O_CALL_ENTER(O_CALL_ENTER), .O_VECTOR(O_VECTOR), .O_ACK(O_ACK)
);

//--- testbench/iepu_cpu_model.sv
// Behavioural CPU sequencer: ends an instruction every i_len cycles,
// runs a five-cycle return when asked. Assumes busy freezes fetch.
`timescale 1ns/10ps
module iepu_cpu_model (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Control
  input  wire logic i_busy,
  input  wire logic [31:0] i_len,
  input  wire logic i_reti_req,
  // Sequencer flags
  output logic      o_instr_done,
  output logic      o_reti_done
);
  int   cnt_q;   // Cycles into current instruction
  logic reti_q;  // Current instruction is a return

  // A return is never followed by another, so one instruction
  // always runs after it
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q  <= 1;
      reti_q <= 1'b0;
    end
    else if (o_instr_done)
    begin
      cnt_q  <= 1;
      reti_q <= i_reti_req && !reti_q;
    end
    else if (!i_busy)
      cnt_q <= cnt_q + 1;
  end

  assign o_instr_done = !i_busy && cnt_q >= (reti_q ? 5 : i_len);
  assign o_reti_done  = o_instr_done && reti_q;
endmodule

//--- testbench/iepu_top_tb.sv
// Self-checking bench of iepu_top with a behavioural CPU model.
// Assumes the package constants and the bound checker.
`timescale 1ns/10ps
module iepu_top_tb;
  import iepu_pkg::*;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, bwr = 0, bval = 0, reti_req = 0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, baddr = 8'h00, rdata;
  logic [21:0] pend = '0, ack;
  logic        idone, rdone, busy, enter, irq;
  logic [15:0] vec;
  int          len = 1, err_count = 0, compares = 0, n;

  iepu_top u_dut (.I_CLOCK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_BIT_ADDR(baddr), .I_BIT_VAL(bval), .I_BIT_WR(bwr),
    .I_PENDING(pend), .I_INSTR_DONE(idone), .I_RETI_DONE(rdone), .O_CALL_BUSY(busy),
    .O_CALL_ENTER(enter), .O_VECTOR(vec), .O_ACK(ack), .O_IRQ(irq));
  iepu_cpu_model u_cpu (.i_clk(clk), .i_nrst(nrst), .i_busy(busy), .i_len(len),
    .i_reti_req(reti_req), .o_instr_done(idone), .o_reti_done(rdone));

  // ****************************************************
  // Bus and check tasks
  // ****************************************************
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(rdata, e);
  endtask
  // Counts cycles up to entry, gives up at 60
  task automatic wait_enter(output int c);
    c = -1;
    do
    begin
      @(negedge clk);
      c++;
    end while (enter !== 1'b1 && c < 60);
  endtask
  task automatic reti();
    @(posedge clk) reti_req <= 1'b1;
    repeat (40) @(negedge clk) if (rdone === 1'b1) break;
    chk(rdone, 1'b1);
    @(posedge clk) reti_req <= 1'b0;
  endtask
  // Raise flags, expect entry of one order, then service and return
  task automatic go(input logic [21:0] p, input int ord);
    @(posedge clk) pend <= p;
    wait_enter(n);
    chk(vec, IEPU_VEC_BASE + (ord << IEPU_VEC_SHIFT));
    chk(ack, 22'h1 << ord);
    @(posedge clk) pend <= '0;
    reti();
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_regs();
    rdb(8'ha8, 8'h00);
    rdb(8'hb8, 8'hc0);
    rdb(8'he6, 8'h00);
    rdb(8'he7, 8'h00);
    rdb(8'hd9, 8'h00);
    rdb(8'hda, 8'h00);
    wrb(8'ha8, 8'h40);
    rdb(8'ha8, 8'h40);
    wrb(8'hb8, 8'h15);
    rdb(8'hb8, 8'hd5);
    wrb(8'he6, 8'ha5);
    rdb(8'he6, 8'ha5);
    wrb(8'he7, 8'hff);
    rdb(8'he7, 8'hbf);
    wrb(8'h55, 8'hff);
    rdb(8'h55, 8'h00);
    @(posedge clk) {baddr, bval, bwr} <= {8'haf, 1'b1, 1'b1};
    @(posedge clk) {baddr, bval} <= {8'hba, 1'b0};
    @(posedge clk) bwr <= 1'b0;
    rdb(8'ha8, 8'hc0);
    rdb(8'hb8, 8'hd1);
    wrb(8'hb8, 8'h00);
    wrb(8'he6, 8'h00);
    wrb(8'he7, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_route();
    wrb(8'ha8, 8'h82);
    go(22'h2, 1);
    chk(n, IEPU_MIN_RESP);
    for (int i = 0; i < 6; i++)
    begin
      wrb(8'ha8, 8'h80 | (8'h1 << i));
      go(22'h3f, i);
    end
    wrb(8'ha8, 8'h80);
    for (int j = 0; j < 8; j++)
    begin
      wrb(8'he6, 8'h1 << j);
      go(22'h3fffff, 6 + j);
    end
    wrb(8'he6, 8'h00);
    for (int j = 0; j < 8; j++)
    begin
      if (j == IEPU_XEN2_RSVD)
        continue;
      wrb(8'he7, 8'h1 << j);
      go(22'h3fffff, 14 + j);
    end
    wrb(8'he7, 8'h00);
    $display("t_route done");
  endtask
  task automatic t_level();
    wrb(8'ha8, 8'h3f);
    @(posedge clk) pend <= 22'h3f;
    wait_enter(n);
    chk(n, 60);
    wrb(8'ha8, 8'hbf);
    go(22'h3f, 0);
    go(22'h3e, 1);
    for (int i = 0; i < 6; i++)
    begin
      wrb(8'hb8, 8'h1 << i);
      go(22'h3f, i);
    end
    $display("t_level done");
  endtask
  task automatic t_nest();
    wrb(8'hb8, 8'h01);
    wrb(8'ha8, 8'h83);
    wrb(8'hd9, 8'h07);
    rdb(8'hd9, 8'h00);
    @(posedge clk) pend <= 22'h2;
    wait_enter(n);
    chk(vec, 16'h000b);
    @(posedge clk) pend <= 22'h1;
    wait_enter(n);
    chk(vec, 16'h0003);
    rdb(8'hd9, 8'h03);
    chk(irq, 1'b0);
    wrb(8'hda, 8'h02);
    @(negedge clk) chk(irq, 1'b1);
    @(posedge clk) pend <= 22'h2;
    wait_enter(n);
    chk(n, 60);
    reti();
    wait_enter(n);
    chk(n, 60);
    @(posedge clk) len <= 8;
    reti();
    wait_enter(n);
    chk(n, 8 + IEPU_LCALL_CYC);
    chk(vec, 16'h000b);
    @(posedge clk) pend <= '0;
    reti();
    wrb(8'hd9, 8'h07);
    @(negedge clk) chk(irq, 1'b0);
    $display("t_nest done");
  endtask

  // ****************************************************
  // Sequence and verdict
  // ****************************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_route();
    t_level();
    t_nest();
    conclude();
  end
  // Whole run is near 800 cycles
  initial
  begin
    #(40 * 30000);
    err_count++;
    conclude();
  end
endmodule
